// [include/hpc_pkg.sv]
// Purpose: Constants for the host port pin configuration block.
// Assumes: One 125 MHz clock, synchronous active-low reset.
// Notes: Core-side bank is six 24-bit words; host bank is eight bytes.
// Operation
// - After reset every shared pin comes up as general-purpose I/O.
// - Sixteen pins; any pin not used by the host port is a GPIO bit.
// - GPIO governed by control, pin data and pin direction registers only.
// - Mux bit 11 set: low address and data share eight pins, strobed.
// - Mux bit clear: chip select plus three address lines pick one of eight.
// - Pins 8-10,13: strobe/addr8/addr9/addr10, or addr 0,1,2 plus select, or GPIO.
// - Strobe pins: single strobe with read/write, or dual strobes, or GPIO.
// - Request pins: request plus acknowledge, or two requests, or GPIO.
// - Every active-low host pin has programmable polarity, low after reset.
// - Software and hardware reset clear core-side control registers.
// - Control bits 6..1 clear give GPIO; set give host functions.
// - GPIO direction bit 0 is input; 1 drives data register bit.
// - Host sees eight consecutive byte-wide locations.
// - Core sees six 24-bit registers.
// - Host reaches only host bank; core reaches only core bank.
// - Mixed 8, 16 and 24-bit transfers in both directions.
// - Host commands force a core interrupt.
// - Each host-directed interrupt source has its own request line; single-request mode ORs both onto pin 14.
// - Slave only; host starts every access.
// - Host writes load transmit registers; reads return receive registers.
package hpc_pkg;
    localparam int PINS = 16;
    localparam int WORD_W = 24;
    localparam int CORE_REGS = 6;
    // Core-side register indices
    localparam logic [2:0] CR_CTRL = 3'h0;   // core_side_control_reg
    localparam logic [2:0] CR_STAT = 3'h1;
    localparam logic [2:0] CR_PCTL = 3'h2;   // port_control_reg
    localparam logic [2:0] CR_DIR = 3'h3;    // pin_direction_reg
    localparam logic [2:0] CR_DATA = 3'h4;   // pin_data_reg
    localparam logic [2:0] CR_TXRX = 3'h5;   // core transmit / receive word
    // Port control fields
    localparam int PC_GPIO_LO = 1;
    localparam int PC_GPIO_HI = 6;
    localparam int PC_REQ_EN = 1;
    localparam int PC_ACK_EN = 2;
    localparam int PC_ADDR_EN = 3;
    localparam int PC_STRB_EN = 4;
    localparam int PC_SEL_EN = 5;
    localparam int PC_BUS_EN = 6;
    localparam int PC_DUAL_REQ = 7;
    localparam int PC_DUAL_STRB = 8;
    localparam int PC_POL_LO = 12;           // polarity bits 12..16
    localparam int PC_MUX = 11;              // addr_data_mux_select
    localparam int POL_N = 5;
    // Host-side byte addresses
    localparam logic [2:0] HA_CMD = 3'h1;
    localparam logic [2:0] HA_HIGH = 3'h5;
    localparam logic [2:0] HA_MID = 3'h6;
    localparam logic [2:0] HA_LOW = 3'h7;
    localparam logic [WORD_W-1:0] RESET_WORD = 24'h00_0000;
endpackage

// [design/hpc_top.sv]
// Purpose: Host port pin function select, GPIO and a small host byte bank.
// Assumes: Host pins are synchronous to ref_clk; no bus, plain ports.
// Notes: Polarity bits of 1 make a pin active high; reset value is 0.
`timescale 1ns/1ps
`default_nettype none
module hpc_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic core_wr,
    input wire logic core_rd,
    input wire logic [2:0] core_addr,
    input wire logic [23:0] core_wdata,
    output logic [23:0] core_rdata,
    output logic core_cmd_irq,
    input wire logic soft_reset,
    input wire logic [15:0] pin_in,
    output logic [15:0] pin_out,
    output logic [15:0] pin_oe
);
    logic [23:0] ctrl_q;
    logic [23:0] pctl_q;
    logic [15:0] dir_q;
    logic [15:0] data_q;
    logic [23:0] tx_q;      // host_rx_data_regs: core to host
    logic [23:0] rx_q;      // host_tx_data_regs: host to core
    logic rx_full_q;
    logic tx_full_q;
    logic cmd_q;
    logic [7:0] addr_lat_q;
    logic [15:0] pin_q;
    logic strobe_prev_q;
    logic [4:0] pol;
    logic hsel, rd_act, wr_act, strobe;
    logic [2:0] haddr;
    logic [7:0] hrdata;
    logic [15:0] func_en;

    assign pol = pctl_q[hpc_pkg::PC_POL_LO +: hpc_pkg::POL_N];
    assign hsel = pctl_q[hpc_pkg::PC_MUX] ? 1'b1 : (pin_in[13] ^ ~pol[0]);

    // Strobe decode; single or dual strobe
    always_comb begin
        if (pctl_q[hpc_pkg::PC_DUAL_STRB]) begin
            rd_act = pin_in[11] ^ ~pol[1];
            wr_act = pin_in[12] ^ ~pol[2];
        end else begin
            rd_act = (pin_in[12] ^ ~pol[2]) & pin_in[11];
            wr_act = (pin_in[12] ^ ~pol[2]) & ~pin_in[11];
        end
    end
    assign strobe = pctl_q[hpc_pkg::PC_STRB_EN] & hsel & (rd_act | wr_act);

    assign haddr = pctl_q[hpc_pkg::PC_MUX] ? addr_lat_q[2:0] : pin_in[10:8];

    // latch low address on the address strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_reset) begin
            addr_lat_q <= 8'h00;
        end else if (pctl_q[hpc_pkg::PC_MUX] && (pin_in[8] ^ ~pol[3])) begin
            addr_lat_q <= pin_in[7:0];
        end
    end

    // core-side control registers, cleared by both resets
    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_reset) begin
            ctrl_q <= hpc_pkg::RESET_WORD;
            pctl_q <= hpc_pkg::RESET_WORD;
            dir_q <= 16'h0000;
            data_q <= 16'h0000;
        end else if (core_wr) begin
            case (core_addr)
                hpc_pkg::CR_CTRL: ctrl_q <= core_wdata;
                hpc_pkg::CR_PCTL: pctl_q <= core_wdata;
                hpc_pkg::CR_DIR: dir_q <= core_wdata[15:0];
                hpc_pkg::CR_DATA: data_q <= core_wdata[15:0];
                default: ;
            endcase
        end
    end

    // Edge of the host strobe marks one access; host starts it
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            strobe_prev_q <= 1'b0;
        end else begin
            strobe_prev_q <= strobe;
        end
    end

    // byte-wide host bank, 24-bit word assembled
    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_reset) begin
            rx_q <= hpc_pkg::RESET_WORD;
            rx_full_q <= 1'b0;
            cmd_q <= 1'b0;
        end else begin
            if (strobe && !strobe_prev_q && wr_act) begin
                case (haddr)
                    hpc_pkg::HA_HIGH: rx_q[23:16] <= pin_in[7:0];
                    hpc_pkg::HA_MID: rx_q[15:8] <= pin_in[7:0];
                    hpc_pkg::HA_LOW: rx_q[7:0] <= pin_in[7:0];
                    default: ;
                endcase
                // Low byte completes any 8, 16 or 24-bit write
                if (haddr == hpc_pkg::HA_LOW) begin
                    rx_full_q <= 1'b1;
                end
                if (haddr == hpc_pkg::HA_CMD && pin_in[7]) begin
                    cmd_q <= 1'b1;
                end
            end else begin
                if (core_rd && core_addr == hpc_pkg::CR_TXRX) begin
                    rx_full_q <= 1'b0;
                end
                if (core_wr && core_addr == hpc_pkg::CR_STAT) begin
                    cmd_q <= 1'b0;
                end
            end
        end
    end
    assign core_cmd_irq = cmd_q;

    // Core to host word; host read of low byte empties it
    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_reset) begin
            tx_q <= hpc_pkg::RESET_WORD;
            tx_full_q <= 1'b0;
        end else if (core_wr && core_addr == hpc_pkg::CR_TXRX) begin
            // A fresh core word wins over a host read in the same cycle, so it is never lost
            tx_q <= core_wdata;
            tx_full_q <= 1'b1;
        end else if (strobe && !strobe_prev_q && rd_act && haddr == hpc_pkg::HA_LOW) begin
            tx_full_q <= 1'b0;
        end
    end

    // host read mux; host sees only these bytes
    always_comb begin
        case (haddr)
            hpc_pkg::HA_HIGH: hrdata = tx_q[23:16];
            hpc_pkg::HA_MID: hrdata = tx_q[15:8];
            hpc_pkg::HA_LOW: hrdata = tx_q[7:0];
            3'h2: hrdata = {6'h00, ~tx_full_q, tx_full_q};
            default: hrdata = 8'h00;
        endcase
    end

    // function enables, all zero after reset means GPIO
    always_comb begin
        func_en = 16'h0000;
        func_en[7:0] = {8{pctl_q[hpc_pkg::PC_BUS_EN]}};
        func_en[10:8] = {3{pctl_q[hpc_pkg::PC_ADDR_EN]}};
        func_en[12:11] = {2{pctl_q[hpc_pkg::PC_STRB_EN]}};
        func_en[13] = pctl_q[hpc_pkg::PC_SEL_EN];
        func_en[14] = pctl_q[hpc_pkg::PC_REQ_EN];
        func_en[15] = pctl_q[hpc_pkg::PC_ACK_EN];
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_out <= 16'h0000;
            pin_oe <= 16'h0000;
        end else begin
            for (int i = 0; i < hpc_pkg::PINS; i++) begin
                pin_out[i] <= data_q[i];
                pin_oe[i] <= dir_q[i];
                if (func_en[i]) begin
                    pin_oe[i] <= 1'b0;
                end
            end
            if (func_en[0] && strobe && rd_act) begin
                pin_out[7:0] <= hrdata;
                pin_oe[7:0] <= 8'hFF;
            end
            if (func_en[14]) begin
                pin_oe[14] <= 1'b1;
                pin_out[14] <= (pctl_q[hpc_pkg::PC_DUAL_REQ] ? ~rx_full_q
                               : (~rx_full_q | tx_full_q)) ^ ~pol[4];
            end
            if (func_en[15] && pctl_q[hpc_pkg::PC_DUAL_REQ]) begin
                pin_oe[15] <= 1'b1;
                pin_out[15] <= tx_full_q ^ ~pol[4];
            end
        end
    end

    // sampled pins for the GPIO data read
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_q <= 16'h0000;
        end else begin
            pin_q <= pin_in;
        end
    end

    // Core read mux; GPIO view
    always_comb begin
        case (core_addr)
            hpc_pkg::CR_CTRL: core_rdata = ctrl_q;
            hpc_pkg::CR_STAT: core_rdata = {21'h0, cmd_q, ~tx_full_q, rx_full_q};
            hpc_pkg::CR_PCTL: core_rdata = pctl_q;
            hpc_pkg::CR_DIR: core_rdata = {8'h00, dir_q};
            hpc_pkg::CR_DATA: core_rdata = {8'h00, (dir_q & data_q) | (~dir_q & pin_q)};
            hpc_pkg::CR_TXRX: core_rdata = rx_q;
            default: core_rdata = 24'h00_0000;
        endcase
    end

    // Reset leaves every pin released
    a_reset_gpio: assert property (@(posedge ref_clk) !rst_n |=> pin_oe == 16'h0000)
        else $error("pins driven after reset");
    a_gpio_dir: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (pctl_q[6:1] == 6'h00 && $stable(dir_q)) |=> pin_oe == $past(dir_q))
        else $error("gpio direction mismatch");

    // Host write edge on the command byte with its request bit set
    sequence s_cmd_write;
        strobe && !strobe_prev_q && wr_act && haddr == hpc_pkg::HA_CMD && pin_in[7];
    endsequence

    // Host write edge on the low byte, which completes a word
    sequence s_low_write;
        strobe && !strobe_prev_q && wr_act && haddr == hpc_pkg::HA_LOW;
    endsequence

    // Host read edge on the low byte, which empties the core word
    sequence s_low_read;
        strobe && !strobe_prev_q && rd_act && haddr == hpc_pkg::HA_LOW;
    endsequence

    // Host read cycle while the data pins belong to the port
    sequence s_host_read;
        func_en[0] && strobe && rd_act;
    endsequence

    // soft reset clears control and direction
    a_soft_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        soft_reset |=> (pctl_q == hpc_pkg::RESET_WORD) && (dir_q == 16'h0000))
        else $error("soft reset left control bits set");

    // host command raises the core request
    a_host_cmd: assert property (@(posedge ref_clk) disable iff (!rst_n || soft_reset)
        s_cmd_write |=> core_cmd_irq)
        else $error("host command not flagged");

    // core write to status drops the request
    a_cmd_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core_wr && core_addr == hpc_pkg::CR_STAT && !(strobe && !strobe_prev_q && wr_act))
        |=> !core_cmd_irq)
        else $error("host command not cleared");

    // low byte completes any transfer width
    a_word_full: assert property (@(posedge ref_clk) disable iff (!rst_n || soft_reset)
        s_low_write |=> rx_full_q)
        else $error("host word not marked full");

    // host read of low byte empties the core word
    a_tx_empty: assert property (@(posedge ref_clk) disable iff (!rst_n || soft_reset)
        s_low_read ##0 !(core_wr && core_addr == hpc_pkg::CR_TXRX) |=> !tx_full_q)
        else $error("core word not emptied");

    // read data driven on the data pins
    a_read_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_host_read |=> (pin_oe[7:0] == 8'hFF) && (pin_out[7:0] == $past(hrdata)))
        else $error("host read data not driven");

    // address strobe latches the low address
    a_mux_latch: assert property (@(posedge ref_clk) disable iff (!rst_n || soft_reset)
        (pctl_q[hpc_pkg::PC_MUX] && (pin_in[8] ^ ~pol[3])) |=> addr_lat_q == $past(pin_in[7:0]))
        else $error("address not latched");

    // claimed data pins stay released outside reads
    a_bus_input: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (pctl_q[hpc_pkg::PC_BUS_EN] && !(strobe && rd_act)) |=> pin_oe[7:0] == 8'h00)
        else $error("data pins driven while idle");

    a_addr_input: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pctl_q[hpc_pkg::PC_ADDR_EN] |=> pin_oe[10:8] == 3'b000)
        else $error("address pins driven");

    // claimed select pin is an input
    a_sel_input: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pctl_q[hpc_pkg::PC_SEL_EN] |=> !pin_oe[13])
        else $error("select pin driven");

    a_strobe_input: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pctl_q[hpc_pkg::PC_STRB_EN] |=> pin_oe[12:11] == 2'b00)
        else $error("strobe pins driven");

    // request pin is an output when claimed
    a_req_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pctl_q[hpc_pkg::PC_REQ_EN] |=> pin_oe[14])
        else $error("request pin not driven");

    // second request pin drives only in double-request mode
    a_dual_req: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (pctl_q[hpc_pkg::PC_ACK_EN] && pctl_q[hpc_pkg::PC_DUAL_REQ]) |=> pin_oe[15])
        else $error("receive request pin not driven");

    // acknowledge pin is an input in single-request mode
    a_ack_input: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (pctl_q[hpc_pkg::PC_ACK_EN] && !pctl_q[hpc_pkg::PC_DUAL_REQ]) |=> !pin_oe[15])
        else $error("acknowledge pin driven");
endmodule // hpc_top
`default_nettype wire

// [test/hpc_host_model.sv]
// Purpose: Far-side host model that settles the level of each of the sixteen pins.
// Assumes: Host levels come from the bench; the block drives wherever pin_oe is high.
// Notes: Passive host side only; it never starts an access by itself.
`timescale 1ns/1ps
`default_nettype none
module hpc_host_model (
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] host_lv,
    output logic [15:0] pin_in
);
    // passive pin resolve
    // Block wins where it drives; elsewhere the host level, never a stale copy
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & host_lv);
endmodule // hpc_host_model
`default_nettype wire

// [test/hpc_top_tb.sv]
// Purpose: Self-checking bench for pin function select and GPIO of the host port.
// Assumes: Core bank reached through plain strobes; host pins resolved by a model.
// Notes: Random GPIO traffic from a fixed xorshift seed, plus reset and mode corners.
`timescale 1ns/1ps
`default_nettype none
module hpc_top_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic core_wr = 1'b0;
    logic core_rd = 1'b0;
    logic [2:0] core_addr = 3'h0;
    logic [23:0] core_wdata = 24'h00_0000;
    logic [23:0] core_rdata;
    logic core_cmd_irq;
    logic soft_reset = 1'b0;
    logic [15:0] pin_in, pin_out, pin_oe;
    logic [15:0] host_lv = 16'hA5C3;
    logic [23:0] rd_q;
    logic [31:0] seed = 32'h0000_36CD;
    int mismatches = 0;
    int tests_run = 0;
    logic [15:0] dir_v, dat_v;
    logic [7:0] hb;

    always #4 ref_clk = ~ref_clk;

    hpc_top hpc_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .core_wr(core_wr),
        .core_rd(core_rd), .core_addr(core_addr), .core_wdata(core_wdata),
        .core_rdata(core_rdata), .core_cmd_irq(core_cmd_irq), .soft_reset(soft_reset),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    hpc_host_model hpc_host_model_inst (.pin_out(pin_out), .pin_oe(pin_oe),
        .host_lv(host_lv), .pin_in(pin_in));

    // Xorshift keeps the random run repeatable
    function automatic logic [31:0] next_rand(logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Expected GPIO readback: stored bit for outputs, pin level for inputs
    function automatic logic [23:0] gpio_read(logic [15:0] d, logic [15:0] r, logic [15:0] h);
        return {8'h00, (d & r) | (~d & h)};
    endfunction

    task automatic check(logic [23:0] seen, logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic core_write(logic [2:0] a, logic [23:0] v);
        @(posedge ref_clk);
        core_wr <= 1'b1;
        core_addr <= a;
        core_wdata <= v;
        @(posedge ref_clk);
        core_wr <= 1'b0;
    endtask

    // Read data is combinational, so it is taken mid-cycle while the strobe stands
    task automatic core_read(logic [2:0] a);
        @(posedge ref_clk);
        core_rd <= 1'b1;
        core_addr <= a;
        @(negedge ref_clk);
        rd_q = core_rdata;
        @(posedge ref_clk);
        core_rd <= 1'b0;
    endtask

    // One host access on the pins; multiplexed mode adds an address phase first
    task automatic host_cycle(logic mux, logic rd, logic [2:0] a, logic [7:0] d);
        @(posedge ref_clk);
        if (mux) begin
            host_lv <= {8'h3E, 5'h00, a};
            @(posedge ref_clk);
        end
        host_lv <= {4'h0, rd, (mux ? 3'b111 : a), d};
        @(posedge ref_clk);
        @(negedge ref_clk);
        hb = pin_in[7:0];
        @(posedge ref_clk);
        host_lv <= 16'h3900;
        @(posedge ref_clk);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog sized well beyond the few hundred cycles the tests need
    initial begin
        #(8 * 20000);
        mismatches++;
        complete_run();
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        check({8'h00, pin_oe}, 24'h00_0000);
        check({23'h0, core_cmd_irq}, 24'h00_0000);
        core_read(hpc_pkg::CR_PCTL);
        check(rd_q, 24'h00_0000);
        core_read(hpc_pkg::CR_DATA);
        check(rd_q, gpio_read(16'h0000, 16'h0000, host_lv));
        $display("reset defaults done");
        // Random GPIO traffic, all-ones and all-zeros directions as corners
        for (int i = 0; i < 40; i++) begin
            seed = next_rand(seed);
            dir_v = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : seed[15:0];
            dat_v = seed[31:16];
            core_write(hpc_pkg::CR_DIR, {8'h00, dir_v});
            core_write(hpc_pkg::CR_DATA, {8'h00, dat_v});
            host_lv <= ~seed[23:8];
            @(posedge ref_clk);
            @(negedge ref_clk);
            check({8'h00, pin_oe}, {8'h00, dir_v});
            check({8'h00, pin_out & dir_v}, {8'h00, dat_v & dir_v});
            core_read(hpc_pkg::CR_DATA);
            check(rd_q, gpio_read(dir_v, dat_v, host_lv));
        end
        $display("gpio random done");
        // Host functions claim pins: idle strobes and select keep pins 0-13 undriven; the request pin drives
        host_lv <= 16'h3800;
        core_write(hpc_pkg::CR_DIR, 24'h00_FFFF);
        core_write(hpc_pkg::CR_DATA, 24'h00_3800);
        core_write(hpc_pkg::CR_PCTL, 24'h00_087E);
        @(posedge ref_clk);
        @(negedge ref_clk);
        check({10'h000, pin_oe[13:0]}, 24'h00_0000);
        core_read(hpc_pkg::CR_PCTL);
        check(rd_q, 24'h00_087E);
        core_write(hpc_pkg::CR_PCTL, 24'h00_0000);
        @(posedge ref_clk);
        @(negedge ref_clk);
        check({8'h00, pin_oe}, 24'h00_FFFF);
        $display("mode select done");
        // Soft reset in mid-run returns everything to GPIO inputs
        core_write(hpc_pkg::CR_PCTL, 24'h00_087E);
        @(posedge ref_clk);
        soft_reset <= 1'b1;
        @(posedge ref_clk);
        soft_reset <= 1'b0;
        core_read(hpc_pkg::CR_PCTL);
        check(rd_q, 24'h00_0000);
        core_read(hpc_pkg::CR_DIR);
        check(rd_q, 24'h00_0000);
        @(negedge ref_clk);
        check({8'h00, pin_oe}, 24'h00_0000);
        $display("soft reset done");
        // Host traffic: non-multiplexed word, byte, command and readback
        @(posedge ref_clk);
        host_lv <= 16'h3900;
        core_write(hpc_pkg::CR_PCTL, 24'h00_007E);
        host_cycle(1'b0, 1'b0, hpc_pkg::HA_HIGH, 8'h12);
        host_cycle(1'b0, 1'b0, hpc_pkg::HA_MID, 8'h34);
        host_cycle(1'b0, 1'b0, hpc_pkg::HA_LOW, 8'h56);
        core_read(hpc_pkg::CR_STAT);
        check({23'h0, rd_q[0]}, 24'h00_0001);
        core_read(hpc_pkg::CR_TXRX);
        check(rd_q, 24'h12_3456);
        host_cycle(1'b0, 1'b0, hpc_pkg::HA_LOW, 8'hAB);
        core_read(hpc_pkg::CR_TXRX);
        check(rd_q, 24'h12_34AB);
        host_cycle(1'b0, 1'b0, hpc_pkg::HA_CMD, 8'h80);
        check({23'h0, core_cmd_irq}, 24'h00_0001);
        core_write(hpc_pkg::CR_STAT, 24'h00_0000);
        @(negedge ref_clk);
        check({23'h0, core_cmd_irq}, 24'h00_0000);
        core_write(hpc_pkg::CR_TXRX, 24'hC0_FFEE);
        @(negedge ref_clk);
        check({23'h0, pin_oe[14]}, 24'h00_0001);
        host_cycle(1'b0, 1'b1, 3'h2, 8'h00);
        check({16'h0000, hb}, 24'h00_0001);
        host_cycle(1'b0, 1'b1, hpc_pkg::HA_HIGH, 8'h00);
        check({16'h0000, hb}, 24'h00_00C0);
        host_cycle(1'b0, 1'b1, hpc_pkg::HA_MID, 8'h00);
        check({16'h0000, hb}, 24'h00_00FF);
        host_cycle(1'b0, 1'b1, hpc_pkg::HA_LOW, 8'h00);
        check({16'h0000, hb}, 24'h00_00EE);
        host_cycle(1'b0, 1'b1, 3'h2, 8'h00);
        check({16'h0000, hb}, 24'h00_0002);
        // Multiplexed mode: address phase then data phase
        core_write(hpc_pkg::CR_PCTL, 24'h00_087E);
        host_cycle(1'b1, 1'b0, hpc_pkg::HA_LOW, 8'h5A);
        core_read(hpc_pkg::CR_TXRX);
        check(rd_q, 24'h12_345A);
        host_cycle(1'b1, 1'b1, hpc_pkg::HA_MID, 8'h00);
        check({16'h0000, hb}, 24'h00_00FF);
        $display("host port done");
        complete_run();
    end
endmodule // hpc_top_tb
`default_nettype wire
